// ==== bench/bcr_host_model.sv ====
// Host software side: classic Wishbone master, one request at a time
module bcr_host_model (
    input wire logic mclk,
    output logic wb_cyc,
    output logic wb_stb,
    output logic wb_we,
    output logic [7:0] wb_adr,
    output logic [3:0] wb_sel,
    output logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle at time zero
    initial begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0000_0000;
    end

    // Request held until ack is sampled high, released at that edge
    task automatic cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= wdat;
        @(posedge mclk);
        while (wb_ack !== 1'b1) @(posedge mclk);
        rdat = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : cycle
endmodule : bcr_host_model

// ==== bench/test_bridge_control_register.sv ====
module test_bridge_control_register;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] wdat;
        logic [31:0] exp;
    } bcr_row_type;
    typedef struct packed {
        logic [31:0] ctrl;
        logic up;
        logic [31:0] addr;
        logic exp;
    } bcr_io_type;

    // Write, read back, expected read
    localparam bcr_row_type ROWS [6] = '{
        '{8'h3C, 4'hF, 32'hFFFF_FFFF, 32'h03EF_0000},
        '{8'h3C, 4'h3, 32'h0000_0000, 32'h03EF_0000},
        '{8'h3C, 4'hF, 32'h00A5_0000, 32'h00A5_0000},
        '{8'h60, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
        '{8'h54, 4'hE, 32'h0000_000F, 32'h0000_0000},
        '{8'h54, 4'hF, 32'h0000_000F, 32'h0000_000F}};
    // I/O decode cases, base 40 and limit 1FFFF
    localparam bcr_io_type IOS [9] = '{
        '{32'h0004_0000, 1'b0, 32'h0000_0100, 1'b0},
        '{32'h0000_0000, 1'b0, 32'h0000_0100, 1'b1},
        '{32'h0004_0000, 1'b0, 32'h0000_0080, 1'b1},
        '{32'h0004_0000, 1'b0, 32'h0000_0010, 1'b0},
        '{32'h0004_0000, 1'b1, 32'h0002_0100, 1'b1},
        '{32'h0004_0000, 1'b0, 32'h0001_0100, 1'b1},
        '{32'h0004_0000, 1'b1, 32'h0000_0100, 1'b1},
        '{32'h0004_0000, 1'b1, 32'h0000_0050, 1'b0},
        '{32'h000C_0000, 1'b0, 32'h0000_03C0, 1'b1}};

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [8:0] ev = 9'h000;
    logic rep_en = 1'b0;
    logic ab_rd = 1'b0;
    logic io_valid = 1'b0;
    logic io_up = 1'b0;
    logic [31:0] io_addr = 32'h0000_0000;
    logic mem_valid = 1'b0;
    logic [31:0] mem_addr = 32'h0000_0000;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq_q, par_rep, par_en, pse_n, ta, r1, wd, r1_n, r2_n, fb;
    logic io_fwd, mem_fwd;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dw, wb_dr, ma_dat, rd;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    bcr_host_model bcr_host_model_i (.mclk(mclk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dw), .wb_dat_r(wb_dr),
        .wb_ack(wb_ack));

    bcr_bridge_control bcr_bridge_control_i (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .irq_q(irq_q),
        .sec_parity_error(ev[0]), .sec_parity_report_q(par_rep), .sec_parity_check_en_q(par_en),
        .sec_port_one_system_error_n(~ev[7]), .sec_port_two_system_error_n(~ev[8]),
        .primary_serr_report_en(rep_en), .primary_system_error_n(pse_n),
        .sec_master_abort(ev[6]), .sec_master_abort_read(ab_rd), .ma_target_abort_q(ta),
        .ma_read_ones_q(r1), .ma_write_discard_q(wd), .ma_read_data_q(ma_dat),
        .sec_port_one_reset_out_n(r1_n), .sec_port_two_reset_out_n(r2_n), .fast_b2b_en_q(fb),
        .pri_master_timeout(ev[1]), .sec_master_timeout(ev[2]), .pri_discard_expired(ev[3]),
        .sec_one_discard_expired(ev[4]), .sec_two_discard_expired(ev[5]), .io_valid(io_valid),
        .io_upstream(io_up), .io_addr(io_addr), .io_base(32'h0000_0040),
        .io_limit(32'h0001_FFFF), .io_forward_q(io_fwd), .mem_valid(mem_valid),
        .mem_addr(mem_addr), .mem_forward_q(mem_fwd));

    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
        bcr_host_model_i.cycle(1'b1, adr, sel, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
        bcr_host_model_i.cycle(1'b0, adr, 4'hF, 32'h0000_0000, rd);
        chk(rd === exp, msg);
    endtask : rd_chk

    // One-cycle event on the chosen inputs, returns once the answer has landed
    task automatic pulse(input logic [8:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 9'h000;
        #1;
    endtask : pulse

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        chk(r1_n === 1'b0 && r2_n === 1'b0 && pse_n === 1'b1, "reset outputs");
        reset_n <= 1'b1;
        rd_chk(8'h3C, 32'h0000_0000, "control reset");
        chk(r1_n === 1'b1 && par_en === 1'b0 && fb === 1'b0, "released outputs");
        // Ordinary register rows
        foreach (ROWS[i]) begin
            wr(ROWS[i].adr, ROWS[i].sel, ROWS[i].wdat);
            rd_chk(ROWS[i].adr, ROWS[i].exp, "row readback");
            if (ROWS[i].adr == 8'h3C) begin
                chk(par_en === ROWS[i].exp[16] && fb === ROWS[i].exp[23], "ctrl copy");
                chk(r1_n === !ROWS[i].exp[22] && r2_n === !ROWS[i].exp[22], "sec reset");
            end
        end
        // Master timeout sticky status, write-one clear, interrupt
        pulse(9'h004);
        @(posedge mclk);
        #1;
        chk(irq_q === 1'b1, "irq on timeout");
        rd_chk(8'h3C, 32'h04A5_0000, "timeout status");
        wr(8'h3C, 4'h8, 32'h0000_0000);
        rd_chk(8'h3C, 32'h04A5_0000, "zero keeps status");
        wr(8'h3C, 4'h8, 32'h0400_0000);
        rd_chk(8'h3C, 32'h00A5_0000, "one clears status");
        wr(8'h54, 4'hF, 32'h0000_0000);
        rd_chk(8'h50, 32'h0000_0001, "irq status sticky");
        chk(irq_q === 1'b0, "irq masked");
        wr(8'h50, 4'h1, 32'h0000_0001);
        rd_chk(8'h50, 32'h0000_0000, "irq status clear");
        pulse(9'h002);
        rd_chk(8'h3C, 32'h04A5_0000, "primary timeout");
        // Expiry in the landing cycle of a clearing write wins
        fork
            wr(8'h3C, 4'h8, 32'h0400_0000);
            begin
                repeat (2) @(posedge mclk);
                ev <= 9'h004;
                @(posedge mclk);
                ev <= 9'h000;
            end
        join
        rd_chk(8'h3C, 32'h04A5_0000, "set beats clear");
        // Discard expiry on each timer
        for (int k = 3; k < 6; k++) begin
            wr(8'h3C, 4'h8, 32'h0C00_0000);
            pulse(9'h001 << k);
            chk(pse_n === 1'b0, "discard serr");
            rd_chk(8'h3C, 32'h08A5_0000, "discard status");
        end
        // Secondary system error forwarding
        pulse(9'h080);
        chk(pse_n === 1'b1, "serr blocked");
        wr(8'h3C, 4'hF, 32'h00A7_0000);
        pulse(9'h100);
        chk(pse_n === 1'b0, "serr forwarded");
        // Parity response both ways
        pulse(9'h001);
        chk(par_rep === 1'b1, "parity reported");
        wr(8'h3C, 4'hF, 32'h0020_0000);
        pulse(9'h001);
        chk(par_rep === 1'b0, "parity ignored");
        // Master abort modes
        @(posedge mclk);
        rep_en <= 1'b1;
        pulse(9'h040);
        chk(ta === 1'b1 && pse_n === 1'b0 && r1 === 1'b0, "abort reported");
        wr(8'h3C, 4'hF, 32'h0000_0000);
        ab_rd <= 1'b1;
        pulse(9'h040);
        chk(r1 === 1'b1 && ta === 1'b0 && pse_n === 1'b1, "abort read ones");
        chk(ma_dat === 32'hFFFF_FFFF, "abort read data");
        @(posedge mclk);
        ab_rd <= 1'b0;
        pulse(9'h040);
        chk(wd === 1'b1 && ta === 1'b0, "abort write discard");
        // I/O decode cases
        foreach (IOS[i]) begin
            wr(8'h3C, 4'hF, IOS[i].ctrl);
            @(posedge mclk);
            io_valid <= 1'b1;
            io_up <= IOS[i].up;
            io_addr <= IOS[i].addr;
            @(posedge mclk);
            io_valid <= 1'b0;
            #1;
            chk(io_fwd === IOS[i].exp, "io decode");
        end
        // Display memory forwarding, enabled then disabled
        for (int k = 0; k < 2; k++) begin
            wr(8'h3C, 4'hF, k == 0 ? 32'h0008_0000 : 32'h0000_0000);
            @(posedge mclk);
            mem_valid <= 1'b1;
            mem_addr <= 32'h000A_0000;
            @(posedge mclk);
            mem_valid <= 1'b0;
            #1;
            chk(mem_fwd === (k == 0), "display memory");
        end
        // Mid-run reset clears fields, status and outputs
        wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
        wr(8'h54, 4'hF, 32'h0000_000F);
        pulse(9'h024);
        @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        #1;
        chk(r1_n === 1'b0 && r2_n === 1'b0 && pse_n === 1'b1, "mid reset");
        chk(irq_q === 1'b0 && wb_ack === 1'b0 && fb === 1'b0, "mid reset idle");
        @(posedge mclk);
        reset_n <= 1'b1;
        rd_chk(8'h3C, 32'h0000_0000, "control after reset");
        rd_chk(8'h54, 32'h0000_0000, "mask after reset");
        chk(r1_n === 1'b1 && r2_n === 1'b1, "reset released");
        finish_test();
    end
endmodule : test_bridge_control_register

// ==== core/bcr_bridge_control.sv ====
// Notes on behaviour
// - Bit 16 enables secondary parity error detection and reporting; clear ignores them.
// - Bit 17 gates forwarding of either secondary system error to primary.
// - Legacy I/O filtering applies only inside base/limit and first 64KB.
// - Bit 18 set blocks downstream forwarding of top 768 bytes per 1KB.
// - Bit 18 set forwards secondary I/O upstream for those top 768 bytes.
// - Bit 19 forwards display memory and I/O downstream regardless of windows.
// - Bit 20 and bits 31 to 28 read zero, reset zero.
// - Bit 21 clear: master aborts unreported, reads return all ones, writes dropped.
// - Bit 21 set: master aborts give target abort, and primary system error only when primary_serr_report_en is set.
// - Bit 22 set holds both secondary reset outputs asserted.
// - Bit 23 allows fast back-to-back transactions to different secondary devices.
// - Bits 24 and 25 store and return written value, reset zero.
// - Bit 26 sets on primary or secondary master timeout expiry.
// - Bit 27 sets on any discard timer expiry and asserts primary system error.
module bcr_bridge_control #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_q,
    input wire logic sec_parity_error,
    output logic sec_parity_report_q,
    output logic sec_parity_check_en_q,
    input wire logic sec_port_one_system_error_n,
    input wire logic sec_port_two_system_error_n,
    input wire logic primary_serr_report_en,
    output logic primary_system_error_n,
    input wire logic sec_master_abort,
    input wire logic sec_master_abort_read,
    output logic ma_target_abort_q,
    output logic ma_read_ones_q,
    output logic ma_write_discard_q,
    output logic [31:0] ma_read_data_q,
    output logic sec_port_one_reset_out_n,
    output logic sec_port_two_reset_out_n,
    output logic fast_b2b_en_q,
    input wire logic pri_master_timeout,
    input wire logic sec_master_timeout,
    input wire logic pri_discard_expired,
    input wire logic sec_one_discard_expired,
    input wire logic sec_two_discard_expired,
    input wire logic io_valid,
    input wire logic io_upstream,
    input wire logic [31:0] io_addr,
    input wire logic [31:0] io_base,
    input wire logic [31:0] io_limit,
    output logic io_forward_q,
    input wire logic mem_valid,
    input wire logic [31:0] mem_addr,
    output logic mem_forward_q
);

    // Address bus must reach the highest register offset
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("bcr_bridge_control: ADDR_W below 8");
    end

    logic [7:0] ctrl_q;
    logic [1:0] rsvd_q;
    logic [1:0] stat_q;
    logic [1:0] stat_set;
    logic [1:0] stat_clr;
    logic [3:0] irq_st_q;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic [3:0] irq_mask_q;
    logic ack_d;
    logic wr_fire;
    logic [7:0] adr_byte;
    logic sel_ctrl;
    logic sel_irq_st;
    logic sel_irq_mask;
    logic [31:0] rd_data;
    logic mto_ev;
    logic discard_ev;
    logic serr_fwd_ev;
    logic ma_serr_ev;
    logic serr_cause;
    logic io_in_range;
    logic io_legacy;
    logic io_isa_alias;
    logic io_disp;
    logic mem_disp;

    // Address decode, word aligned
    assign adr_byte = {wb_adr_i[7:2], 2'h0};
    assign sel_ctrl = adr_byte == bcr_pkg::BRIDGE_CONTROL_OFF;
    assign sel_irq_st = adr_byte == bcr_pkg::IRQ_STATUS_OFF;
    assign sel_irq_mask = adr_byte == bcr_pkg::IRQ_MASK_OFF;

    // Writes land on the edge that the master sees ack
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Bus acknowledge, one wait state, dropped after one cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= ack_d;
        end
    end

    // Read mux, unmapped reads zero, read-only reserved bits zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_data[23:16] = ctrl_q & bcr_pkg::CTRL_BYTE_WMASK;
            rd_data[bcr_pkg::RSVD_RW_HI_BIT:bcr_pkg::RSVD_RW_LO_BIT] = rsvd_q;
            rd_data[bcr_pkg::DISCARD_STAT_BIT:bcr_pkg::MTO_STAT_BIT] = stat_q;
        end else if (sel_irq_st) begin
            rd_data[bcr_pkg::IRQ_W-1:0] = irq_st_q;
        end else if (sel_irq_mask) begin
            rd_data[bcr_pkg::IRQ_W-1:0] = irq_mask_q;
        end
    end

    // Read data captured with ack
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ack_d && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    // Control byte, bit 20 never stored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= bcr_pkg::CTRL_BYTE_RESET;
        end else if (wr_fire && sel_ctrl && wb_sel_i[2]) begin
            ctrl_q <= wb_dat_i[23:16] & bcr_pkg::CTRL_BYTE_WMASK;
        end
    end

    // Reserved but writable pair
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rsvd_q <= bcr_pkg::RSVD_RW_RESET;
        end else if (wr_fire && sel_ctrl && wb_sel_i[3]) begin
            rsvd_q <= wb_dat_i[bcr_pkg::RSVD_RW_HI_BIT:bcr_pkg::RSVD_RW_LO_BIT];
        end
    end

    // Expiry events
    assign mto_ev = pri_master_timeout || sec_master_timeout;
    assign discard_ev = pri_discard_expired || sec_one_discard_expired
        || sec_two_discard_expired;
    assign stat_set = {discard_ev, mto_ev};
    assign stat_clr = (wr_fire && sel_ctrl && wb_sel_i[3])
        ? wb_dat_i[bcr_pkg::DISCARD_STAT_BIT:bcr_pkg::MTO_STAT_BIT] : 2'h0;

    // Timeout status bits 26 and 27
    bcr_sticky #(
        .WIDTH(2)
    ) u_stat (
        .mclk(mclk),
        .reset_n(reset_n),
        .set(stat_set),
        .clr(stat_clr),
        .state_q(stat_q)
    );

    // Interrupt events and status
    assign irq_set = {serr_fwd_ev, sec_parity_error && ctrl_q[0], discard_ev, mto_ev};
    assign irq_clr = (wr_fire && sel_irq_st && wb_sel_i[0])
        ? wb_dat_i[bcr_pkg::IRQ_W-1:0] : 4'h0;

    bcr_sticky #(
        .WIDTH(bcr_pkg::IRQ_W)
    ) u_irq (
        .mclk(mclk),
        .reset_n(reset_n),
        .set(irq_set),
        .clr(irq_clr),
        .state_q(irq_st_q)
    );

    // Interrupt mask and level output
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_q <= bcr_pkg::IRQ_MASK_RESET;
        end else if (wr_fire && sel_irq_mask && wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[bcr_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    // Secondary parity handling
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_parity_check_en_q <= 1'b0;
            sec_parity_report_q <= 1'b0;
        end else begin
            sec_parity_check_en_q <= ctrl_q[0];
            sec_parity_report_q <= sec_parity_error && ctrl_q[0];
        end
    end

    // System error sources toward primary
    assign serr_fwd_ev = ctrl_q[1]
        && (!sec_port_one_system_error_n || !sec_port_two_system_error_n);
    assign ma_serr_ev = sec_master_abort && ctrl_q[5] && primary_serr_report_en;
    assign serr_cause = serr_fwd_ev || ma_serr_ev || discard_ev;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            primary_system_error_n <= 1'b1;
        end else begin
            primary_system_error_n <= !serr_cause;
        end
    end

    // Master abort completion by mode
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ma_target_abort_q <= 1'b0;
            ma_read_ones_q <= 1'b0;
            ma_write_discard_q <= 1'b0;
        end else begin
            ma_target_abort_q <= sec_master_abort && ctrl_q[5];
            ma_read_ones_q <= sec_master_abort && !ctrl_q[5] && sec_master_abort_read;
            ma_write_discard_q <= sec_master_abort && !ctrl_q[5] && !sec_master_abort_read;
        end
    end

    // Fill data for unreported aborted reads
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ma_read_data_q <= 32'h0000_0000;
        end else if (sec_master_abort && !ctrl_q[5] && sec_master_abort_read) begin
            ma_read_data_q <= bcr_pkg::ALL_ONES;
        end
    end

    // Secondary resets follow primary reset or the software force
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_port_one_reset_out_n <= 1'b0;
            sec_port_two_reset_out_n <= 1'b0;
        end else begin
            sec_port_one_reset_out_n <= !ctrl_q[6];
            sec_port_two_reset_out_n <= !ctrl_q[6];
        end
    end

    // Fast back-to-back permission
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fast_b2b_en_q <= 1'b0;
        end else begin
            fast_b2b_en_q <= ctrl_q[7];
        end
    end

    // I/O decode: window, legacy alias and display ranges
    assign io_in_range = (io_addr >= io_base) && (io_addr <= io_limit);
    assign io_legacy = io_in_range && (io_addr[31:16] == bcr_pkg::IO_HIGH_ZERO);
    assign io_isa_alias = ctrl_q[2] && io_legacy
        && (io_addr[9:8] != bcr_pkg::ISA_LOW_QUARTER);
    assign io_disp = ctrl_q[3] && (io_addr[31:16] == bcr_pkg::IO_HIGH_ZERO)
        && (((io_addr[9:0] >= bcr_pkg::DISP_IO_A_LO) && (io_addr[9:0] <= bcr_pkg::DISP_IO_A_HI))
        || ((io_addr[9:0] >= bcr_pkg::DISP_IO_B_LO) && (io_addr[9:0] <= bcr_pkg::DISP_IO_B_HI)));
    assign mem_disp = ctrl_q[3] && (mem_addr >= bcr_pkg::DISP_MEM_LO)
        && (mem_addr <= bcr_pkg::DISP_MEM_HI);

    // I/O forwarding verdict
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            io_forward_q <= 1'b0;
        end else if (!io_valid) begin
            io_forward_q <= 1'b0;
        end else if (io_upstream) begin
            io_forward_q <= !io_disp && (!io_in_range || io_isa_alias);
        end else begin
            io_forward_q <= io_disp || (io_in_range && !io_isa_alias);
        end
    end

    // Memory forwarding of display range
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_forward_q <= 1'b0;
        end else begin
            mem_forward_q <= mem_valid && mem_disp;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_parity_gate: assert property (!ctrl_q[0] |=> !sec_parity_report_q)
        else $error("parity reported while ignored");
    a_serr_forward: assert property ((ctrl_q[1] && !sec_port_two_system_error_n)
        |=> !primary_system_error_n)
        else $error("secondary system error not forwarded");
    a_serr_quiet: assert property ((!ctrl_q[1] && !sec_master_abort && !discard_ev)
        |=> primary_system_error_n)
        else $error("system error forwarded while disabled");
    a_legacy_high: assert property ((io_valid && !io_upstream && io_in_range && !io_disp
        && io_addr[31:16] != 16'h0000) |=> io_forward_q)
        else $error("I/O above 64KB wrongly filtered");
    a_isa_block: assert property ((io_valid && !io_upstream && io_isa_alias && !io_disp)
        |=> !io_forward_q)
        else $error("legacy alias forwarded downstream");
    a_isa_upstream: assert property ((io_valid && io_upstream && io_isa_alias && !io_disp)
        |=> io_forward_q)
        else $error("legacy alias not forwarded upstream");
    a_disp_mem: assert property ((mem_valid && ctrl_q[3] && mem_addr == 32'h000A_0000)
        |=> mem_forward_q)
        else $error("display memory not forwarded");
    a_reserved_zero: assert property ((wb_ack_o && !wb_we_i && $past(sel_ctrl))
        |-> (wb_dat_o[20] == 1'b0 && wb_dat_o[31:28] == 4'h0))
        else $error("reserved bits read nonzero");
    a_ma_ones: assert property ((sec_master_abort && sec_master_abort_read && !ctrl_q[5])
        |=> (ma_read_ones_q && ma_read_data_q == 32'hFFFF_FFFF && !ma_target_abort_q))
        else $error("aborted read not filled with ones");
    a_ma_report: assert property ((sec_master_abort && ctrl_q[5] && primary_serr_report_en)
        |=> (ma_target_abort_q && !primary_system_error_n))
        else $error("master abort not reported");
    a_sec_reset: assert property (ctrl_q[6] |=> (!sec_port_one_reset_out_n
        && !sec_port_two_reset_out_n))
        else $error("secondary reset not forced");
    a_fast_b2b: assert property ($rose(ctrl_q[7]) |=> fast_b2b_en_q)
        else $error("fast back-to-back not enabled");
    a_rsvd_store: assert property ((wr_fire && sel_ctrl && wb_sel_i[3])
        |=> rsvd_q == $past(wb_dat_i[25:24]))
        else $error("reserved writable bits not stored");
    a_mto_set: assert property (sec_master_timeout
        |=> stat_q[0] ##1 (stat_q[0] || $past(stat_clr[0])))
        else $error("master timeout status not set");
    a_discard_set: assert property (sec_two_discard_expired
        |=> (stat_q[1] && !primary_system_error_n))
        else $error("discard expiry not flagged");
    a_w1c_keep: assert property ((stat_q[0] && !stat_clr[0]) |=> stat_q[0])
        else $error("status bit lost without clear");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    c_write_ctrl: cover property (wr_fire && sel_ctrl && wb_sel_i[2]);
    c_clear_race: cover property (mto_ev && stat_clr[0]);
    c_irq_raise: cover property ($rose(irq_q));
    c_isa_block: cover property (io_valid && !io_upstream && io_isa_alias);

endmodule : bcr_bridge_control

// ==== core/bcr_pkg.sv ====
package bcr_pkg;

    // Register byte offsets
    localparam logic [7:0] BRIDGE_CONTROL_OFF = 8'h3C;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'h50;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h54;

    // Bridge control field positions
    localparam int PARITY_RESP_BIT = 16;
    localparam int SERR_FWD_BIT = 17;
    localparam int ISA_FILTER_BIT = 18;
    localparam int DISPLAY_FWD_BIT = 19;
    localparam int RSVD_RO_BIT = 20;
    localparam int MA_MODE_BIT = 21;
    localparam int SEC_RESET_BIT = 22;
    localparam int FAST_B2B_BIT = 23;
    localparam int RSVD_RW_LO_BIT = 24;
    localparam int RSVD_RW_HI_BIT = 25;
    localparam int MTO_STAT_BIT = 26;
    localparam int DISCARD_STAT_BIT = 27;

    // Control byte at bits 23:16, writable mask excludes the reserved bit
    localparam logic [7:0] CTRL_BYTE_WMASK = 8'hEF;
    localparam logic [7:0] CTRL_BYTE_RESET = 8'h00;
    localparam logic [1:0] RSVD_RW_RESET = 2'h0;

    // Interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IRQ_MTO = 0;
    localparam int IRQ_DISCARD = 1;
    localparam int IRQ_PARITY = 2;
    localparam int IRQ_SERR_FWD = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // Master abort read fill
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

    // Legacy I/O decode: first 64KB, top 768 bytes of every 1KB block
    localparam logic [15:0] IO_HIGH_ZERO = 16'h0000;
    localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;

    // Display compatible ranges
    localparam logic [31:0] DISP_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] DISP_MEM_HI = 32'h000B_FFFF;
    localparam logic [9:0] DISP_IO_A_LO = 10'h3B0;
    localparam logic [9:0] DISP_IO_A_HI = 10'h3BB;
    localparam logic [9:0] DISP_IO_B_LO = 10'h3C0;
    localparam logic [9:0] DISP_IO_B_HI = 10'h3DF;

endpackage : bcr_pkg

// ==== core/bcr_sticky.sv ====
// Sticky event bits, write one to clear, set wins over clear
module bcr_sticky #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] state_q
);

    logic [WIDTH-1:0] state_d;

    // Keep old bits unless cleared, new events always land
    always_comb begin
        state_d = (state_q & ~clr) | set;
    end

    // State register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : bcr_sticky
